// ---- verilog/srx_pkg.sv ----
// srx_pkg: constants for the receiver auxiliary-bit capture block
// assumes an apb slave with 32-bit data, one register per aligned word
package srx_pkg;

	// register indices; the byte address is four times the index
	localparam logic [15:0] IDX_ROUTE_CTRL    = 16'hf60e;
	localparam logic [15:0] IDX_READY_FLAG    = 16'hf60f;
	localparam logic [15:0] IDX_CS_LEFT_FIRST = 16'hf610;
	localparam logic [15:0] IDX_CS_LEFT_LAST  = 16'hf61b;
	localparam logic [15:0] IDX_IRQ_STATUS    = 16'hf6f0;
	localparam logic [15:0] IDX_IRQ_ENABLE    = 16'hf6f1;
	localparam logic [15:0] IDX_IRQ_CLEAR     = 16'hf6f2;

	// field positions of the route control register
	localparam int ROUTE_SEL_LSB = 0;
	localparam int ROUTE_SEL_W   = 4;
	localparam int ROUTE_CLK_BIT = 4;

	// reset values
	localparam logic [3:0]  ROUTE_SEL_RST = 4'h0;
	localparam logic        ROUTE_CLK_RST = 1'b0;
	localparam logic [15:0] CS_WORD_RST   = 16'h0000;

	// block geometry
	localparam int FRAMES_PER_BLOCK = 192;
	localparam int CS_WORDS         = 12;
	localparam int CS_WORD_W        = 16;
	localparam int FRAME_CNT_W      = 8;
	localparam logic [7:0] LAST_FRAME = 8'(FRAMES_PER_BLOCK - 1);

	// tdm8 layout: eight slots of 32 bits, 24 data bits then 8 padding
	localparam int TDM_SLOTS   = 8;
	localparam int TDM_SLOT_W  = 32;
	localparam int TDM_FRAME_W = TDM_SLOTS * TDM_SLOT_W;
	localparam int AUDIO_W     = 24;
	localparam int TDM_PAD_W   = 8;

	// interrupt status bits
	localparam int IRQ_BLOCK_DONE = 0;
	localparam int IRQ_PARITY_ERR = 1;
	localparam int IRQ_W          = 2;

endpackage : srx_pkg

// ---- verilog/srx_aux_capture.sv ----
// srx_aux_capture: captures channel status bits of the left subframe over
// a 192-frame block, reports a ready flag, and renders the received
// stream as tdm8 on one of four serial data lanes.
// assumes a decoder ahead of it gives one i_frame_valid pulse per frame,
// and that recovered and generated serial clocks are synchronous levels.
//
// Notes on behaviour
// - four-bit one-hot routing field, reset zero, picks serial data lane 0-3.
// - routing field of zero puts the stream on no lane at all.
// - take left channel status bits frame by frame over 192, not user, validity or parity.
// - ready flag bit 0 goes from zero to one after all 192 frames.
// - ready high means the captured block is complete and readable.
// - ready flag is read-only, resets to zero, one means bits available.
// - 192 left channel status bits are held across twelve 16-bit words.
// - status words sit at consecutive word addresses, one per register.
// - status words are read-only and reset to zero.
// - clock-source bit: zero uses recovered clocks, one generated clocks.
// - tdm slot 0 left audio, slot 4 right audio, each padded by eight zeros.
module srx_aux_capture
	import srx_pkg::*;
(
	// clock and reset
	input  wire logic              i_clk,
	input  wire logic              i_reset_n,
	// apb slave
	input  wire logic              i_psel,
	input  wire logic              i_penable,
	input  wire logic              i_pwrite,
	input  wire logic [31:0]       i_paddr,
	input  wire logic [31:0]       i_pwdata,
	output logic      [31:0]       o_prdata,
	output logic                   o_pready,
	output logic                   o_pslverr,
	// decoded frames from the receiver
	input  wire logic              i_frame_valid,
	input  wire logic              i_block_start,
	input  wire logic [AUDIO_W-1:0] i_left_audio,
	input  wire logic [AUDIO_W-1:0] i_right_audio,
	input  wire logic [3:0]        i_left_pvuc,
	input  wire logic [3:0]        i_right_pvuc,
	input  wire logic              i_compressed,
	input  wire logic              i_dts,
	// serial clock sources
	input  wire logic              i_rec_bclk,
	input  wire logic              i_rec_fclk,
	input  wire logic              i_gen_bclk,
	input  wire logic              i_gen_fclk,
	// tdm output lanes and their clocks
	output logic                   o_serial_data_out_lane0,
	output logic                   o_serial_data_out_lane1,
	output logic                   o_serial_data_out_lane2,
	output logic                   o_serial_data_out_lane3,
	output logic                   o_lane_bclk,
	output logic                   o_lane_fclk,
	// interrupt
	output logic                   o_irq
);

	// pvuc ports carry {parity, validity, user, channel status}
	localparam int PVUC_CS = 0;

	function automatic logic is_one_hot(input logic [3:0] v);
		return (v == 4'h1) || (v == 4'h2) || (v == 4'h4) || (v == 4'h8);
	endfunction : is_one_hot

	function automatic logic [TDM_SLOT_W-1:0] pad_slot(
		input logic [AUDIO_W-1:0] v);
		return {v, {TDM_PAD_W{1'b0}}};
	endfunction : pad_slot

	function automatic logic parity_bad(input logic [AUDIO_W-1:0] a,
		input logic [3:0] pvuc);
		return ^{a, pvuc};
	endfunction : parity_bad

	// ---------------- register state ----------------
	logic [ROUTE_SEL_W-1:0]   rx_tdm_route_sel;
	logic                     rx_tdm_route_clk_src;
	logic                     aux_block_ready;
	logic [CS_WORD_W-1:0]     cs_left [CS_WORDS];
	logic [FRAMES_PER_BLOCK-1:0] cs_work;
	logic [FRAME_CNT_W-1:0]   frame_cnt;
	logic                     in_block;
	logic [IRQ_W-1:0]         irq_status;
	logic [IRQ_W-1:0]         irq_enable;

	// ---------------- apb decode ----------------
	logic        setup_phase;
	logic        access_done;
	logic [15:0] reg_idx;
	logic        addr_ok;
	logic        cs_hit;
	logic [3:0]  cs_word_sel;
	logic [31:0] next_prdata;
	logic        next_mapped;
	logic        wr_ctrl;
	logic        wr_enable;
	logic        wr_clear;

	assign setup_phase = i_psel && !i_penable;
	assign access_done = i_psel && i_penable && o_pready;
	assign reg_idx     = i_paddr[17:2];
	assign addr_ok     = (i_paddr[31:18] == 14'h0) && (i_paddr[1:0] == 2'h0);
	assign cs_hit      = (reg_idx >= IDX_CS_LEFT_FIRST) &&
	                     (reg_idx <= IDX_CS_LEFT_LAST);
	assign cs_word_sel = 4'(reg_idx - IDX_CS_LEFT_FIRST);

	always_comb begin
		next_prdata = 32'h0;
		next_mapped = addr_ok;
		if (cs_hit) begin
			next_prdata[CS_WORD_W-1:0] = cs_left[cs_word_sel];
		end else begin
			unique case (reg_idx)
				IDX_ROUTE_CTRL: begin
					next_prdata[ROUTE_SEL_LSB +: ROUTE_SEL_W] = rx_tdm_route_sel;
					next_prdata[ROUTE_CLK_BIT] = rx_tdm_route_clk_src;
				end
				IDX_READY_FLAG: begin
					next_prdata[0] = aux_block_ready;
				end
				IDX_IRQ_STATUS: begin
					next_prdata[IRQ_W-1:0] = irq_status;
				end
				IDX_IRQ_ENABLE: begin
					next_prdata[IRQ_W-1:0] = irq_enable;
				end
				IDX_IRQ_CLEAR: begin
					next_prdata = 32'h0;
				end
				default: begin
					next_mapped = 1'b0;
				end
			endcase
		end
		if (!addr_ok) begin
			next_mapped = 1'b0;
		end
	end

	// answer is prepared in the setup cycle so the access phase has no wait
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_pready  <= 1'b0;
			o_pslverr <= 1'b0;
			o_prdata  <= 32'h0;
		end else begin
			o_pready  <= setup_phase;
			o_pslverr <= setup_phase && !next_mapped;
			o_prdata  <= (setup_phase && !i_pwrite && next_mapped) ?
			             next_prdata : 32'h0;
		end
	end

	// writes to read-only words are dropped without error
	assign wr_ctrl   = access_done && i_pwrite && addr_ok &&
	                   (reg_idx == IDX_ROUTE_CTRL);
	assign wr_enable = access_done && i_pwrite && addr_ok &&
	                   (reg_idx == IDX_IRQ_ENABLE);
	assign wr_clear  = access_done && i_pwrite && addr_ok &&
	                   (reg_idx == IDX_IRQ_CLEAR);

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rx_tdm_route_sel     <= ROUTE_SEL_RST;
			rx_tdm_route_clk_src <= ROUTE_CLK_RST;
		end else if (wr_ctrl) begin
			rx_tdm_route_sel     <= i_pwdata[ROUTE_SEL_LSB +: ROUTE_SEL_W];
			rx_tdm_route_clk_src <= i_pwdata[ROUTE_CLK_BIT];
		end
	end

	// ---------------- block capture ----------------
	// frames before the first block start are ignored: without the start
	// marker the position of a bit inside the block is unknown
	logic last_frame;

	assign last_frame = i_frame_valid && in_block && !i_block_start &&
	                    (frame_cnt == LAST_FRAME);

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			frame_cnt <= '0;
			in_block  <= 1'b0;
		end else if (i_frame_valid) begin
			if (i_block_start) begin
				frame_cnt <= 8'h1;
				in_block  <= 1'b1;
			end else if (in_block) begin
				frame_cnt <= (frame_cnt == LAST_FRAME) ? '0 : frame_cnt + 8'h1;
				in_block  <= (frame_cnt != LAST_FRAME);
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			cs_work <= '0;
		end else if (i_frame_valid && i_block_start) begin
			cs_work[0] <= i_left_pvuc[PVUC_CS];
		end else if (i_frame_valid && in_block) begin
			cs_work[frame_cnt] <= i_left_pvuc[PVUC_CS];
		end
	end

	// a finished block is copied whole, so software never sees a mix
	// of two blocks; the last bit is merged in during the copy
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			for (int w = 0; w < CS_WORDS; w++) begin
				cs_left[w] <= CS_WORD_RST;
			end
		end else if (last_frame) begin
			for (int w = 0; w < CS_WORDS - 1; w++) begin
				cs_left[w] <= cs_work[w*CS_WORD_W +: CS_WORD_W];
			end
			cs_left[CS_WORDS-1] <= {i_left_pvuc[PVUC_CS],
				cs_work[FRAMES_PER_BLOCK-2 -: CS_WORD_W-1]};
		end
	end

	// once set the flag stays: every later block replaces the words at once
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			aux_block_ready <= 1'b0;
		end else if (last_frame) begin
			aux_block_ready <= 1'b1;
		end
	end

	// ---------------- interrupts ----------------
	logic [IRQ_W-1:0] irq_event;

	always_comb begin
		irq_event = '0;
		irq_event[IRQ_BLOCK_DONE] = last_frame;
		irq_event[IRQ_PARITY_ERR] = i_frame_valid &&
			(parity_bad(i_left_audio, i_left_pvuc) ||
			 parity_bad(i_right_audio, i_right_pvuc));
	end

	// a new event in the clearing cycle is kept
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			irq_status <= '0;
		end else begin
			irq_status <= (irq_status & ~(wr_clear ? i_pwdata[IRQ_W-1:0] : '0))
			              | irq_event;
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			irq_enable <= '0;
		end else if (wr_enable) begin
			irq_enable <= i_pwdata[IRQ_W-1:0];
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_irq <= 1'b0;
		end else begin
			o_irq <= |(irq_status & irq_enable);
		end
	end

	// ---------------- tdm8 rendering ----------------
	logic [TDM_FRAME_W-1:0] tdm_latched;
	logic [TDM_FRAME_W-1:0] tdm_shift;
	logic                   sel_bclk;
	logic                   sel_fclk;
	logic                   bclk_q;
	logic                   fclk_at_fall;
	logic                   bclk_fall;
	logic                   frame_begin;
	logic                   tdm_bit;

	assign sel_bclk = rx_tdm_route_clk_src ? i_gen_bclk : i_rec_bclk;
	assign sel_fclk = rx_tdm_route_clk_src ? i_gen_fclk : i_rec_fclk;

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			tdm_latched <= '0;
		end else if (i_frame_valid) begin
			tdm_latched <= {
				pad_slot(i_left_audio),
				pad_slot({20'h0, i_left_pvuc}),
				pad_slot({22'h0, i_dts, i_compressed}),
				32'h0,
				pad_slot(i_right_audio),
				pad_slot({20'h0, i_right_pvuc}),
				32'h0,
				pad_slot({23'h0, i_block_start})
			};
		end
	end

	assign bclk_fall   = bclk_q && !sel_bclk;
	assign frame_begin = sel_fclk && !fclk_at_fall;

	// data changes on the falling bit clock; a rising frame clock seen at
	// a fall reloads the whole frame from slot 0
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			bclk_q       <= 1'b0;
			fclk_at_fall <= 1'b0;
			tdm_shift    <= '0;
			tdm_bit      <= 1'b0;
		end else begin
			bclk_q <= sel_bclk;
			if (bclk_fall) begin
				fclk_at_fall <= sel_fclk;
				if (frame_begin) begin
					tdm_bit   <= tdm_latched[TDM_FRAME_W-1];
					tdm_shift <= {tdm_latched[TDM_FRAME_W-2:0], 1'b0};
				end else begin
					tdm_bit   <= tdm_shift[TDM_FRAME_W-1];
					tdm_shift <= {tdm_shift[TDM_FRAME_W-2:0], 1'b0};
				end
			end
		end
	end

	// a code that is not one-hot is treated like zero
	logic lane_on;

	assign lane_on = is_one_hot(rx_tdm_route_sel);

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_serial_data_out_lane0 <= 1'b0;
			o_serial_data_out_lane1 <= 1'b0;
			o_serial_data_out_lane2 <= 1'b0;
			o_serial_data_out_lane3 <= 1'b0;
			o_lane_bclk             <= 1'b0;
			o_lane_fclk             <= 1'b0;
		end else begin
			o_serial_data_out_lane0 <= lane_on && rx_tdm_route_sel[0] &&
			                           tdm_bit;
			o_serial_data_out_lane1 <= lane_on && rx_tdm_route_sel[1] &&
			                           tdm_bit;
			o_serial_data_out_lane2 <= lane_on && rx_tdm_route_sel[2] &&
			                           tdm_bit;
			o_serial_data_out_lane3 <= lane_on && rx_tdm_route_sel[3] &&
			                           tdm_bit;
			// clocks go out only while a lane is routed; the port of that
			// lane must be a clock master for them to reach a pin
			o_lane_bclk <= lane_on && sel_bclk;
			o_lane_fclk <= lane_on && sel_fclk;
		end
	end

endmodule : srx_aux_capture

// ---- bench/srx_assertions.sv ----
// srx_assertions: port-level checks for srx_aux_capture
// assumes a zero-wait apb slave; bound from the bench top file
module srx_assertions
	import srx_pkg::*;
(
	// clock and apb
	input wire logic        i_clk,
	input wire logic        i_reset_n,
	input wire logic        i_psel,
	input wire logic        i_penable,
	input wire logic        i_pwrite,
	input wire logic [31:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [31:0] o_prdata,
	input wire logic        o_pready,
	input wire logic        o_pslverr,
	// frames and clocks
	input wire logic        i_frame_valid,
	input wire logic        i_block_start,
	input wire logic        i_rec_bclk,
	input wire logic        i_gen_bclk,
	// lanes
	input wire logic        o_serial_data_out_lane0,
	input wire logic        o_serial_data_out_lane1,
	input wire logic        o_serial_data_out_lane2,
	input wire logic        o_serial_data_out_lane3,
	input wire logic        o_lane_bclk,
	input wire logic        o_lane_fclk
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] sh;
	logic       src;
	logic [7:0] cnt;
	logic       done;
	logic [3:0] lanes;
	logic       cs_hit;
	logic       exp_b;
	assign lanes = {o_serial_data_out_lane3, o_serial_data_out_lane2,
		o_serial_data_out_lane1, o_serial_data_out_lane0};
	assign cs_hit = i_paddr[31:18] == 14'h0 && i_paddr[1:0] == 2'h0 &&
		i_paddr[17:2] >= IDX_CS_LEFT_FIRST && i_paddr[17:2] <= IDX_CS_LEFT_LAST;
	assign exp_b = $onehot(sh) && (src ? i_gen_bclk : i_rec_bclk);
	// shadow of the route field, taken at the same edge the write lands
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			sh  <= 4'h0;
			src <= 1'b0;
		end else if (i_psel && i_penable && o_pready && i_pwrite &&
			i_paddr == {14'h0, IDX_ROUTE_CTRL, 2'h0}) begin
			sh  <= i_pwdata[3:0];
			src <= i_pwdata[4];
		end
	end
	// cnt of zero means no block open: frames before a start are ignored
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			cnt  <= 8'h0;
			done <= 1'b0;
		end else if (i_frame_valid && i_block_start) begin
			cnt <= 8'h1;
		end else if (i_frame_valid && cnt == LAST_FRAME) begin
			cnt  <= 8'h0;
			done <= 1'b1;
		end else if (i_frame_valid && cnt != 8'h0) begin
			cnt <= cnt + 8'h1;
		end
	end
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_reset_n);
	a_pready_setup: assert property (i_psel && !i_penable |=> o_pready)
		else $error("no pready after setup");
	a_pready_cause: assert property (o_pready |-> $past(i_psel && !i_penable))
		else $error("pready without setup");
	a_err_misalign: assert property (o_pready && i_paddr[1:0] != 2'h0
		|-> o_pslverr) else $error("misaligned access accepted");
	a_prdata_idle: assert property (!o_pready |-> o_prdata == 32'h0)
		else $error("read data outside access");
	a_err_rdata: assert property (o_pready && o_pslverr |-> o_prdata == 32'h0)
		else $error("read data on refused access");
	a_ready_flag: assert property (
		o_pready && !i_pwrite && i_paddr == {14'h0, IDX_READY_FLAG, 2'h0}
		|-> o_prdata == {31'h0, $past(done)}) else $error("ready flag wrong");
	a_cs_width: assert property (o_pready && !i_pwrite && cs_hit
		|-> !o_pslverr && o_prdata[31:16] == 16'h0)
		else $error("status word read wrong");
	a_lane_clk: assert property (o_lane_bclk == $past(exp_b))
		else $error("lane bit clock wrong");
	a_lane_off: assert property ($past(sh) == 4'h0
		|-> !o_lane_bclk && !o_lane_fclk) else $error("clock on idle lane");
	a_lane_sel: assert property ($onehot0(lanes) &&
		(lanes & ~($past(sh) | $past(sh, 2))) == 4'h0)
		else $error("data on unselected lane");
	c_ready: cover property (done && !$past(done));
	c_lane: cover property (lanes != 4'h0);
	c_err: cover property (o_pslverr);
endmodule : srx_assertions

// ---- bench/srx_src_model.sv ----
// srx_src_model: behavioural source of decoded s/pdif frames
// assumes the bench calls send_frames; recovered clocks idle between
module srx_src_model
	import srx_pkg::*;
(
	// clock
	input wire logic         i_clk,
	// frame stream and recovered clocks
	output logic             o_frame_valid,
	output logic             o_block_start,
	output logic [AUDIO_W-1:0] o_left_audio,
	output logic [AUDIO_W-1:0] o_right_audio,
	output logic [3:0]       o_left_pvuc,
	output logic [3:0]       o_right_pvuc,
	output logic             o_compressed,
	output logic             o_dts,
	output logic             o_rec_bclk,
	output logic             o_rec_fclk
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0]  lfsr = 16'h97e6;
	logic [9:0]   ccnt = 10'h0;
	logic         run = 1'b0;
	logic [191:0] cs_bits = '0;
	function automatic logic [15:0] step(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : step
	always @(posedge i_clk) begin
		if (run)
			ccnt <= ccnt + 10'h1;
	end
	assign o_rec_bclk = ccnt[1];
	assign o_rec_fclk = ccnt[9:2] == 8'h0;
	initial begin
		o_frame_valid = 1'b0;
		o_block_start = 1'b0;
		{o_left_audio, o_right_audio, o_left_pvuc, o_right_pvuc} = '0;
		{o_compressed, o_dts} = 2'h0;
	end
	task automatic send_frames(input int n, input logic start);
		logic [23:0] a;
		for (int i = 0; i < n; i++) begin
			@(posedge i_clk);
			lfsr = step(lfsr);
			a = {lfsr, lfsr[7:0]};
			cs_bits[i] = lfsr[0];
			run <= 1'b1;
			o_frame_valid <= 1'b1;
			o_block_start <= start && i == 0;
			o_left_audio <= a;
			o_right_audio <= ~a;
			// even parity kept, so only block-done events are raised
			o_left_pvuc <= {^{a, lfsr[0]}, 2'b00, lfsr[0]};
			o_right_pvuc <= {^(~a), 3'b000};
			{o_compressed, o_dts} <= lfsr[2:1];
			@(posedge i_clk);
			// released lines show the inverse, never the last value
			o_frame_valid <= 1'b0;
			o_left_audio <= ~a;
			o_right_audio <= a;
			o_left_pvuc <= ~o_left_pvuc;
			o_right_pvuc <= ~o_right_pvuc;
			o_block_start <= ~o_block_start;
			{o_compressed, o_dts} <= ~lfsr[2:1];
			repeat (6) @(posedge i_clk);
		end
		run <= 1'b0;
	endtask : send_frames
endmodule : srx_src_model

// ---- bench/srx_tb.sv ----
// tb: apb master, frame source and result monitor for srx_aux_capture
// assumes design, checker and source model are compiled first
module tb
	import srx_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        i_clk = 1'b0;
	logic        i_reset_n = 1'b0;
	logic        i_psel = 1'b0;
	logic        i_penable = 1'b0;
	logic        i_pwrite = 1'b0;
	logic [31:0] i_paddr = 32'h0;
	logic [31:0] i_pwdata = 32'h0;
	logic [31:0] o_prdata;
	logic        o_pready, o_pslverr, o_irq, o_lane_bclk, o_lane_fclk;
	logic        i_frame_valid, i_block_start, i_compressed, i_dts;
	logic [23:0] i_left_audio, i_right_audio;
	logic [3:0]  i_left_pvuc, i_right_pvuc;
	logic        i_rec_bclk, i_rec_fclk, i_gen_bclk, i_gen_fclk;
	logic        o_serial_data_out_lane0, o_serial_data_out_lane1;
	logic        o_serial_data_out_lane2, o_serial_data_out_lane3;
	logic [10:0] gcnt = 11'h0;
	logic [32:0] notes[$];
	int          num_errors = 0;
	int          n_tests = 0;
	logic [255:0] tdm_cap = '0;
	logic         lbclk_q = 1'b0;
	int           tdm_n = 0;
	initial forever #12.5 i_clk = ~i_clk;
	always @(posedge i_clk) gcnt <= gcnt + 11'h1;
	assign i_gen_bclk = gcnt[2];
	assign i_gen_fclk = gcnt[10:3] == 8'h0;
	srx_aux_capture dut_u (
		.i_clk, .i_reset_n, .i_psel, .i_penable, .i_pwrite, .i_paddr,
		.i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_frame_valid,
		.i_block_start, .i_left_audio, .i_right_audio, .i_left_pvuc,
		.i_right_pvuc, .i_compressed, .i_dts, .i_rec_bclk, .i_rec_fclk,
		.i_gen_bclk, .i_gen_fclk, .o_serial_data_out_lane0,
		.o_serial_data_out_lane1, .o_serial_data_out_lane2,
		.o_serial_data_out_lane3, .o_lane_bclk, .o_lane_fclk, .o_irq);
	srx_src_model src_u (.i_clk, .o_frame_valid(i_frame_valid),
		.o_block_start(i_block_start), .o_left_audio(i_left_audio),
		.o_right_audio(i_right_audio), .o_left_pvuc(i_left_pvuc),
		.o_right_pvuc(i_right_pvuc), .o_compressed(i_compressed),
		.o_dts(i_dts), .o_rec_bclk(i_rec_bclk), .o_rec_fclk(i_rec_fclk));
	task automatic end_sim();
		if (num_errors == 0 && n_tests > 0 && notes.size() == 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : end_sim
	task automatic cmp(input logic [32:0] e, input logic [32:0] g);
		n_tests++;
		if (g !== e) begin
			num_errors++;
			$display("mismatch at %0t: expected %h got %h", $time, e, g);
		end
	endtask : cmp
	function automatic logic [31:0] ba(input logic [15:0] idx);
		return {14'h0, idx, 2'h0};
	endfunction : ba
	task automatic apb(input logic wr, input logic [31:0] a,
		input logic [31:0] d, input logic [32:0] e);
		int k;
		@(posedge i_clk);
		i_psel <= 1'b1;
		i_pwrite <= wr;
		i_paddr <= a;
		i_pwdata <= d;
		if (!wr)
			notes.push_back(e);
		@(posedge i_clk);
		i_penable <= 1'b1;
		k = 0;
		do begin
			@(posedge i_clk);
			k++;
		end while (o_pready !== 1'b1 && k < 20);
		if (k >= 20)
			num_errors++;
		if (k >= 20)
			end_sim();
		i_psel <= 1'b0;
		i_penable <= 1'b0;
	endtask : apb
	task automatic rd(input logic [15:0] i, input logic [31:0] d);
		apb(1'b0, ba(i), 32'h0, {1'b0, d});
	endtask : rd
	task automatic wr(input logic [15:0] i, input logic [31:0] d);
		apb(1'b1, ba(i), d, 33'h0);
	endtask : wr
	always @(posedge i_clk) begin
		if (i_psel && i_penable && o_pready === 1'b1 && !i_pwrite)
			cmp(notes.pop_front(), {o_pslverr, o_prdata});
	end
	// lane 1 capture: bits taken at rises of the lane bit clock, a high
	// frame clock marks the first bit of a frame
	always @(posedge i_clk) begin
		lbclk_q <= o_lane_bclk;
		if (o_lane_bclk && !lbclk_q) begin
			tdm_cap <= {tdm_cap[254:0], o_serial_data_out_lane1};
			tdm_n <= o_lane_fclk ? 1 : tdm_n + 1;
		end
	end
	task automatic tdm_wait(input int n);
		int k;
		k = 0;
		while (tdm_n != n && k < 5000) begin
			@(posedge i_clk);
			k++;
		end
		if (k >= 5000)
			num_errors++;
		if (k >= 5000)
			end_sim();
	endtask : tdm_wait
	// each lane in turn, then off; the stream runs meanwhile
	task automatic route_sweep();
		logic [4:0] v;
		for (int s = 0; s < 5; s++) begin
			v = {s[0], 4'(s < 4 ? 1 << s : 0)};
			wr(IDX_ROUTE_CTRL, {27'h0, v});
			rd(IDX_ROUTE_CTRL, {27'h0, v});
			repeat (250) @(posedge i_clk);
		end
	endtask : route_sweep
	initial begin
		logic [15:0] l;
		logic [23:0] a;
		repeat (12) @(posedge i_clk);
		i_reset_n <= 1'b1;
		for (int w = 0; w < CS_WORDS; w++)
			rd(IDX_CS_LEFT_FIRST + 16'(w), 32'h0);
		rd(IDX_READY_FLAG, 32'h0);
		rd(IDX_ROUTE_CTRL, 32'h0);
		apb(1'b0, ba(IDX_CS_LEFT_LAST) + 32'h4, 32'h0, {1'b1, 32'h0});
		apb(1'b0, ba(IDX_READY_FLAG) + 32'h2, 32'h0, {1'b1, 32'h0});
		wr(IDX_CS_LEFT_FIRST, 32'hffff);
		rd(IDX_CS_LEFT_FIRST, 32'h0);
		wr(IDX_IRQ_ENABLE, 32'h1);
		src_u.send_frames(100, 1'b1);
		rd(IDX_READY_FLAG, 32'h0);
		fork
			src_u.send_frames(FRAMES_PER_BLOCK, 1'b1);
			route_sweep();
		join
		rd(IDX_READY_FLAG, 32'h1);
		for (int w = 0; w < CS_WORDS; w++)
			rd(IDX_CS_LEFT_FIRST + 16'(w), {16'h0, src_u.cs_bits[w*16 +: 16]});
		cmp(33'h1, {32'h0, o_irq});
		rd(IDX_IRQ_STATUS, 32'h1);
		wr(IDX_IRQ_ENABLE, 32'h0);
		repeat (3) @(posedge i_clk);
		cmp(33'h0, {32'h0, o_irq});
		wr(IDX_IRQ_ENABLE, 32'h1);
		wr(IDX_IRQ_CLEAR, 32'h3);
		repeat (3) @(posedge i_clk);
		cmp(33'h0, {32'h0, o_irq});
		rd(IDX_IRQ_STATUS, 32'h0);
		rd(IDX_READY_FLAG, 32'h1);
		apb(1'b0, ba(IDX_READY_FLAG) + 32'h2, 32'h0, {1'b1, 32'h0});
		// one whole frame of the last latched frame, generated clocks
		wr(IDX_ROUTE_CTRL, 32'h12);
		repeat (16) @(posedge i_clk);
		tdm_wait(1);
		tdm_wait(256);
		l = src_u.lfsr;
		a = {l, l[7:0]};
		cmp({1'b0, a, 8'h0}, {1'b0, tdm_cap[255:224]});
		cmp({21'h0, ^{a, l[0]}, 2'b00, l[0], 8'h0}, {1'b0, tdm_cap[223:192]});
		cmp({23'h0, l[1], l[2], 8'h0}, {1'b0, tdm_cap[191:160]});
		cmp(33'h0, {1'b0, tdm_cap[159:128]});
		cmp({1'b0, ~a, 8'h0}, {1'b0, tdm_cap[127:96]});
		cmp({21'h0, ^(~a), 3'b000, 8'h0}, {1'b0, tdm_cap[95:64]});
		cmp(33'h0, {1'b0, tdm_cap[63:32]});
		cmp(33'h0, {1'b0, tdm_cap[31:0]});
		// a code that is not one-hot routes nothing
		wr(IDX_ROUTE_CTRL, 32'h3);
		rd(IDX_ROUTE_CTRL, 32'h3);
		repeat (20) @(posedge i_clk);
		cmp(33'h0, {31'h0, o_lane_bclk, o_serial_data_out_lane0});
		repeat (4) @(posedge i_clk);
		end_sim();
	end
endmodule : tb
bind srx_aux_capture srx_assertions chk_u (.i_clk, .i_reset_n, .i_psel,
	.i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready,
	.o_pslverr, .i_frame_valid, .i_block_start, .i_rec_bclk, .i_gen_bclk,
	.o_serial_data_out_lane0, .o_serial_data_out_lane1,
	.o_serial_data_out_lane2, .o_serial_data_out_lane3, .o_lane_bclk,
	.o_lane_fclk);
